// File: flash_macro_model.sv
// Purpose: flash array read port facing the sequencer
// Assumes: array reads are combinational
// Notes: upper byte fixed so the byte select shows
`timescale 1ns/10ps
module flash_macro_model (
   // Read port
   input wire [14:0] rd_addr,
   output wire [15:0] rd_word
);
   // Low byte follows the address, high byte a marker
   assign rd_word = {8'ha5, rd_addr[7:0]};
endmodule

// File: flash_self_program_regs.vh
// Purpose: register offsets, field positions and timing counts of the
//          self-programming flash sequencer.
// Assumes: 32-bit bus words, one register per aligned word.
// Notes:   included by the sequencer only.
`ifndef FLASH_SELF_PROGRAM_REGS_VH
`define FLASH_SELF_PROGRAM_REGS_VH

// Byte offsets of the registers
`define OFS_CTRL 8'h00
`define OFS_DATA_LOW 8'h04
`define OFS_DATA_HIGH 8'h08
`define OFS_POINTER 8'h0c
`define OFS_STORE 8'h10
`define OFS_LOAD 8'h14

// Control register bit positions
`define BIT_IRQ_EN 7
`define BIT_RWW_BUSY 6
`define BIT_REENABLE 4
`define BIT_LOCK_SET 3
`define BIT_PAGE_WRITE 2
`define BIT_PAGE_ERASE 1
`define BIT_PROG_EN 0

// Lower five control bit patterns
`define PAT_LOAD 5'h01
`define PAT_ERASE 5'h03
`define PAT_WRITE 5'h05
`define PAT_LOCK 5'h09
`define PAT_REENABLE 5'h11

// Reset values
`define RST_CTRL 5'h00
`define RST_LOCK 4'hf
`define RST_BUF_WORD 16'hffff

// Command windows in clock cycles
`define STORE_WINDOW 3'h4
`define LOCK_READ_MIN 3'h2

// Programming time and clock period
`define PROG_TIME_NS 3700000
`define CLK_PERIOD_NS 8

`endif

// File: flash_self_program_sequencer.v
// Purpose: self-programming sequencer for on-chip program flash,
//          reached over AHB-Lite.
// Assumes: one clock, asynchronous active-high reset, flash macro and
//          EEPROM busy on the same clock.
// Notes:   the store and load registers stand in for the core's
//          store-program and load-program instructions.
//
// Behaviour
// - Erase pattern then store within four cycles
// - Erase of halting region halts the core
// - Load pattern plus store fills buffer word
// - Buffer cleared after write, reenable, reset
// - EEPROM write mid-load discards buffer
// - Write pattern plus store programs page
// - Write of halting region halts the core
// - Irq asserted while enable bit clear
// - Erase or write blocks concurrent region reads
// - Busy flag set while region blocked
// - Lock pattern plus store sets lock bits
// - Zero in data bits 5..2 programs lock
// - Pointer ignored during lock set
// - Flash readable while locks are programmed
// - EEPROM busy refuses commands and lock reads
// - Target page latched at operation start
// - Loads select byte by pointer bit zero
// - Buffer words load in any order
// - Enable bit clears after store or timeout
// - Undefined patterns have no effect
// - Buffer load clears busy flag
// - Erase, write, lock take 3.7 ms minimum
`timescale 1ns/10ps
`include "flash_self_program_regs.vh"

module flash_self_program_sequencer #(
   parameter PAGE_W = 7,
   parameter WORD_W = 5,
   parameter HALT_FIRST_PAGE = 96,
   parameter PROG_CYCLES = (`PROG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
   parameter TIMER_W = 20
) (
   // Clock and reset
   input wire clk,
   input wire rst,
   // AHB-Lite slave
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire hreadyout,
   output reg [31:0] hrdata,
   output wire hresp,
   // Core side
   output wire irq_req,
   output reg core_halt_r,
   output wire rww_read_block,
   // EEPROM status and fuse values
   input wire eeprom_write_busy,
   input wire [7:0] fuse_low,
   input wire [7:0] fuse_high,
   input wire [7:0] fuse_ext,
   // Flash macro
   output reg flash_erase_r,
   output reg flash_program_r,
   output reg [PAGE_W-1:0] flash_page_r,
   output wire [14:0] flash_rd_addr,
   input wire [15:0] flash_rd_word,
   input wire [WORD_W-1:0] buf_idx,
   output wire [15:0] buf_word,
   output reg [3:0] lock_bits_r
);

   localparam DEPTH = 1 << WORD_W;
   // First page whose erase or write halts the core
   localparam [PAGE_W-1:0] HALT_PG = HALT_FIRST_PAGE[PAGE_W-1:0];
   localparam [TIMER_W-1:0] PROG_CNT = PROG_CYCLES[TIMER_W-1:0];
   // Sequencer states
   localparam ST_IDLE = 1'b0;
   localparam ST_OP = 1'b1;

   ////////////////////////////////////////////////////////////////////
   // Helpers

   // Page field of a pointer value
   function [PAGE_W-1:0] page_of;
      input [15:0] p;
      begin
         page_of = p[WORD_W+PAGE_W:WORD_W+1];
      end
   endfunction

   // True when the pattern is one of the five commands
   function pat_ok;
      input [4:0] p;
      begin
         pat_ok = (p == `PAT_LOAD) || (p == `PAT_ERASE) ||
            (p == `PAT_WRITE) || (p == `PAT_LOCK) ||
            (p == `PAT_REENABLE);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////
   // State

   reg st_r; // Idle or timed operation
   reg [4:0] cmd_r; // Lower control bits
   reg irq_en_r; // Ready interrupt enable
   reg busy_flag_r; // Concurrent region busy
   reg [2:0] win_r; // Cycles left to issue a store
   reg [TIMER_W-1:0] timer_r; // Operation time left
   reg [7:0] data_low_r; // Low data register
   reg [7:0] data_high_r; // High data register
   reg [15:0] ptr_r; // Address pointer
   reg loaded_r; // Buffer holds loaded words
   reg [15:0] buf_r [0:DEPTH-1]; // Temporary page buffer
   reg ap_wr_r; // Pending data-phase write
   reg [7:0] ap_addr_r; // Its offset
   integer i;

   ////////////////////////////////////////////////////////////////////
   // Bus decode

   // Zero wait states and always OKAY keep the master simple
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   wire ap_take = hsel && hready && htrans[1];
   wire ap_rd = ap_take && !hwrite;
   wire [7:0] ap_ofs = haddr[7:0];
   wire wr_ctrl = ap_wr_r && (ap_addr_r == `OFS_CTRL);
   wire wr_store = ap_wr_r && (ap_addr_r == `OFS_STORE);
   wire [4:0] wpat = hwdata[4:0];

   // Store is honoured only inside the window and with no EEPROM write
   wire store_go = wr_store && (win_r != 3'h0) && (st_r == ST_IDLE) &&
      !eeprom_write_busy;

   // Lock read armed for three cycles after the control write
   wire lock_rd = ap_rd && (ap_ofs == `OFS_LOAD) &&
      (cmd_r == `PAT_LOCK) && (st_r == ST_IDLE) &&
      (win_r >= `LOCK_READ_MIN);

   // Page under the pointer; reads of a halting page stay open while busy
   wire [PAGE_W-1:0] ptr_page = page_of(ptr_r);
   wire halting = ptr_page >= HALT_PG;

   ////////////////////////////////////////////////////////////////////
   // Status outputs

   // Level request for as long as the enable bit reads clear
   assign irq_req = irq_en_r && !cmd_r[`BIT_PROG_EN];
   assign rww_read_block = busy_flag_r;
   // Loads address bytes, so the word address drops bit zero
   assign flash_rd_addr = ptr_r[15:1];
   assign buf_word = buf_r[buf_idx];

   ////////////////////////////////////////////////////////////////////
   // Read data

   // Read value chosen in the address phase, held in the data phase
   reg [31:0] rd_nxt;
   always @* begin
      rd_nxt = 32'h0;
      case (ap_ofs)
         `OFS_CTRL: begin
            rd_nxt[7:0] = {irq_en_r, busy_flag_r, 1'b0, cmd_r};
         end
         `OFS_DATA_LOW: begin
            rd_nxt[7:0] = data_low_r;
         end
         `OFS_DATA_HIGH: begin
            rd_nxt[7:0] = data_high_r;
         end
         `OFS_POINTER: begin
            rd_nxt[15:0] = ptr_r;
         end
         `OFS_LOAD: begin
            if (lock_rd) begin
               if (eeprom_write_busy) begin
                  rd_nxt = 32'h0;
               end else begin
                  case (ptr_r[1:0])
                     2'h0: rd_nxt[7:0] = fuse_low;
                     2'h1: rd_nxt[7:0] = {2'h3, lock_bits_r, 2'h3};
                     2'h2: rd_nxt[7:0] = fuse_ext;
                     default: rd_nxt[7:0] = fuse_high;
                  endcase
               end
            end else if (busy_flag_r && !halting) begin
               // Blocked region reads as zero
               rd_nxt = 32'h0;
            end else if (ptr_r[0]) begin
               rd_nxt[7:0] = flash_rd_word[15:8];
            end else begin
               rd_nxt[7:0] = flash_rd_word[7:0];
            end
         end
         default: begin
            rd_nxt = 32'h0; // Unmapped and store read as zero
         end
      endcase
   end

   // Read data register
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         hrdata <= 32'h0;
      end else if (ap_rd) begin
         hrdata <= rd_nxt;
      end
   end

   // Address phase capture
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         ap_wr_r <= 1'b0;
         ap_addr_r <= 8'h00;
      end else if (hready) begin
         ap_wr_r <= ap_take && hwrite;
         ap_addr_r <= ap_offs_or_zero(ap_take, ap_ofs);
      end
   end

   // Offset kept only for a real transfer
   function [7:0] ap_offs_or_zero;
      input t;
      input [7:0] o;
      begin
         ap_offs_or_zero = t ? o : 8'h00;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Data and pointer registers

   // Plain storage; an operation keeps its own latched page
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         data_low_r <= 8'h00;
         data_high_r <= 8'h00;
         ptr_r <= 16'h0000;
      end else if (ap_wr_r) begin
         if (ap_addr_r == `OFS_DATA_LOW) begin
            data_low_r <= hwdata[7:0];
         end
         if (ap_addr_r == `OFS_DATA_HIGH) begin
            data_high_r <= hwdata[7:0];
         end
         if (ap_addr_r == `OFS_POINTER) begin
            ptr_r <= hwdata[15:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Temporary page buffer

   // Last cycle of a timed operation
   wire op_end = (st_r == ST_OP) && (timer_r == {{(TIMER_W-1){1'b0}}, 1'b1});
   wire buf_we = store_go && (cmd_r == `PAT_LOAD);
   // Clear after a page write, on re-enable, or on an EEPROM write
   // that lands while words are loaded
   wire buf_clr = (op_end && flash_program_r) ||
      (wr_ctrl && wpat == `PAT_REENABLE && st_r == ST_IDLE) ||
      (eeprom_write_busy && loaded_r);

   // Any word may be written in any order, before or after erase
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         loaded_r <= 1'b0;
         for (i = 0; i < DEPTH; i = i + 1) begin
            buf_r[i] <= `RST_BUF_WORD;
         end
      end else if (buf_clr) begin
         loaded_r <= 1'b0;
         for (i = 0; i < DEPTH; i = i + 1) begin
            buf_r[i] <= `RST_BUF_WORD;
         end
      end else if (buf_we) begin
         loaded_r <= 1'b1;
         buf_r[ptr_r[WORD_W:1]] <= {data_high_r, data_low_r};
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Sequencer

   // Control writes, store window, timed operations and flags
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r <= ST_IDLE;
         cmd_r <= `RST_CTRL;
         irq_en_r <= 1'b0;
         busy_flag_r <= 1'b0;
         win_r <= 3'h0;
         timer_r <= {TIMER_W{1'b0}};
         core_halt_r <= 1'b0;
         flash_erase_r <= 1'b0;
         flash_program_r <= 1'b0;
         flash_page_r <= {PAGE_W{1'b0}};
         lock_bits_r <= `RST_LOCK;
      end else if (st_r == ST_OP) begin
         // Enable bit stays set until the timed operation ends
         if (wr_ctrl) begin
            irq_en_r <= hwdata[`BIT_IRQ_EN];
         end
         timer_r <= timer_r - {{(TIMER_W-1){1'b0}}, 1'b1};
         if (op_end) begin
            st_r <= ST_IDLE;
            cmd_r <= `RST_CTRL;
            core_halt_r <= 1'b0;
            flash_erase_r <= 1'b0;
            flash_program_r <= 1'b0;
         end
      end else if (store_go) begin
         win_r <= 3'h0;
         case (cmd_r)
            `PAT_LOAD: begin
               cmd_r <= `RST_CTRL;
               busy_flag_r <= 1'b0;
            end
            `PAT_ERASE, `PAT_WRITE: begin
               // Page latched so the pointer is free from here on
               st_r <= ST_OP;
               timer_r <= PROG_CNT;
               flash_page_r <= ptr_page;
               flash_erase_r <= (cmd_r == `PAT_ERASE);
               flash_program_r <= (cmd_r == `PAT_WRITE);
               busy_flag_r <= !halting;
               core_halt_r <= halting;
            end
            `PAT_LOCK: begin
               // Pointer ignored; reads stay open
               st_r <= ST_OP;
               timer_r <= PROG_CNT;
               lock_bits_r <= lock_bits_r & data_low_r[5:2];
            end
            `PAT_REENABLE: begin
               cmd_r <= `RST_CTRL;
               busy_flag_r <= 1'b0;
            end
            default: begin
               cmd_r <= `RST_CTRL;
            end
         endcase
      end else if (wr_ctrl) begin
         irq_en_r <= hwdata[`BIT_IRQ_EN];
         // Undefined patterns and patterns written under an EEPROM write are dropped
         if (pat_ok(wpat) && !eeprom_write_busy) begin
            cmd_r <= wpat;
            win_r <= `STORE_WINDOW;
         end
      end else if (lock_rd) begin
         // A lock or fuse read consumes the armed command
         cmd_r <= `RST_CTRL;
         win_r <= 3'h0;
      end else if (win_r != 3'h0) begin
         win_r <= win_r - 3'h1;
         if (win_r == 3'h1) begin
            cmd_r <= `RST_CTRL;
         end
      end
   end

endmodule

// File: flash_seq_chk.sv
// Purpose: port-level checks of the flash sequencer
// Assumes: one clock, reset active high
// Notes: bound into every sequencer instance
`timescale 1ns/10ps
module flash_seq_chk #(
   parameter PROG_CYCLES = 20
) (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Bus response
   input wire hreadyout,
   input wire hresp,
   // Status and flash control
   input wire irq_req,
   input wire core_halt_r,
   input wire rww_read_block,
   input wire eeprom_write_busy,
   input wire flash_erase_r,
   input wire flash_program_r,
   input wire [3:0] lock_bits_r
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Erase or write operation in flight
   wire op = flash_erase_r | flash_program_r;
   // Cycles run so far, counted so long waits need no repetition
   reg [31:0] run_r;
   always @(posedge clk or posedge rst) begin
      if (rst)
         run_r <= 32'h0;
      else
         run_r <= op ? run_r + 32'h1 : 32'h0;
   end
   ////////////////////
   a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not okay");
   a_one_op: assert property (!(flash_erase_r && flash_program_r))
      else $error("erase and write together");
   a_halt_in_op: assert property (core_halt_r |-> op) else $error("halt outside op");
   a_rww_blocked: assert property (op && !core_halt_r |-> rww_read_block)
      else $error("region not blocked");
   a_no_irq_busy: assert property (op |-> !irq_req) else $error("irq during op");
   a_eeprom_refuse: assert property ($rose(op) |-> !$past(eeprom_write_busy))
      else $error("op started under eeprom busy");
   a_lock_one_way: assert property ((lock_bits_r & ~$past(lock_bits_r)) == 4'h0)
      else $error("lock bit unprogrammed");
   a_lock_no_halt: assert property (!$stable(lock_bits_r) |-> !core_halt_r)
      else $error("halt while locking");
   a_op_length: assert property ($fell(op) |-> run_r + 1 >= PROG_CYCLES)
      else $error("op too short");
   a_op_cap: assert property (run_r <= PROG_CYCLES + 1) else $error("op too long");
   // Main scenarios reached
   c_erase: cover property ($rose(flash_erase_r));
   c_write: cover property ($rose(flash_program_r));
   c_halt: cover property ($rose(core_halt_r));
   c_lock: cover property (!$stable(lock_bits_r));
endmodule
bind flash_self_program_sequencer flash_seq_chk #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
   .clk(clk), .rst(rst), .hreadyout(hreadyout), .hresp(hresp), .irq_req(irq_req),
   .core_halt_r(core_halt_r), .rww_read_block(rww_read_block),
   .eeprom_write_busy(eeprom_write_busy), .flash_erase_r(flash_erase_r),
   .flash_program_r(flash_program_r), .lock_bits_r(lock_bits_r));

// File: tb_top.sv
// Purpose: self-checking bench of the flash sequencer
// Assumes: zero wait-state bus, short programming time
// Notes: each scenario is one task
`timescale 1ns/10ps
module tb_top;
   // Bus and side inputs
   reg clk, rst, hsel, hwrite, busy;
   reg [31:0] haddr, hwdata, q;
   reg [1:0] htrans;
   reg [4:0] bidx;
   // Design outputs
   wire hrdy, hresp, irq, halt, blk, ers, prg;
   wire [31:0] hrdata;
   wire [6:0] page;
   wire [14:0] raddr;
   wire [15:0] rword, bword;
   wire [3:0] lock;
   integer mismatches, samples_checked, cyc;
   localparam CT = 8'h00, DL = 8'h04, DH = 8'h08, PT = 8'h0c, ST = 8'h10, LD = 8'h14;
   flash_self_program_sequencer #(.PROG_CYCLES(20)) u_dut (
      .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy),
      .hreadyout(hrdy), .hrdata(hrdata), .hresp(hresp), .irq_req(irq),
      .core_halt_r(halt), .rww_read_block(blk), .eeprom_write_busy(busy),
      .fuse_low(8'h11), .fuse_high(8'h22), .fuse_ext(8'h33),
      .flash_erase_r(ers), .flash_program_r(prg), .flash_page_r(page),
      .flash_rd_addr(raddr), .flash_rd_word(rword), .buf_idx(bidx),
      .buf_word(bword), .lock_bits_r(lock));
   flash_macro_model u_flash (.rd_addr(raddr), .rd_word(rword));
   ////////////////////
   // Clock of 8 ns
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Hang guard, far above the run length
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         mismatches = mismatches + 1;
         summarize;
      end
   end
   task chk(input string nm, input [31:0] e, input [31:0] g);
      begin
         samples_checked = samples_checked + 1;
         if (g !== e) begin
            mismatches = mismatches + 1;
            $display("unexpected %s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   // One single transfer; read data lands in q
   task xfer(input w, input [7:0] a, input [31:0] d);
      begin
         @(posedge clk);
         haddr <= {24'h0, a};
         hwrite <= w;
         htrans <= 2'h2;
         @(posedge clk);
         while (hrdy !== 1'b1) @(posedge clk);
         htrans <= 2'h0;
         hwdata <= d;
         @(posedge clk);
         while (hrdy !== 1'b1) @(posedge clk);
         q = hrdata;
      end
   endtask
   // Control pattern, then the store inside the window
   task cmd(input [7:0] p);
      begin
         xfer(1'b1, CT, {24'h0, p});
         xfer(1'b1, ST, 32'h0);
         @(negedge clk);
      end
   endtask
   task ld(input [15:0] p, input [7:0] h, input [7:0] l);
      begin
         xfer(1'b1, PT, {16'h0, p});
         xfer(1'b1, DL, {24'h0, l});
         xfer(1'b1, DH, {24'h0, h});
         cmd(8'h01);
      end
   endtask
   task bchk(input [4:0] i, input [15:0] e);
      begin
         @(posedge clk);
         bidx <= i;
         @(negedge clk);
         chk("buffer word", {16'h0, e}, {16'h0, bword});
      end
   endtask
   task wait_op;
      integer i;
      begin
         for (i = 0; i < 40 && (ers | prg) !== 1'b0; i = i + 1)
            @(negedge clk);
         chk("op end", 32'h0, {31'h0, ers | prg});
      end
   endtask
   ////////////////////
   task t_reset;
      begin
         xfer(1'b0, CT, 32'h0);
         chk("ctrl", 32'h0, q);
         chk("lock bits", 32'hf, {28'h0, lock});
         bchk(5'h7, 16'hffff);
         xfer(1'b1, CT, 32'h60);
         xfer(1'b0, CT, 32'h0);
         chk("ctrl read only", 32'h0, q);
         xfer(1'b1, 8'h40, 32'hffffffff);
         xfer(1'b0, 8'h40, 32'h0);
         chk("unmapped", 32'h0, q);
      end
   endtask
   task t_load;
      begin
         ld(16'h0007, 8'h12, 8'h34);
         ld(16'h0002, 8'h56, 8'h78);
         bchk(5'h3, 16'h1234);
         bchk(5'h1, 16'h5678);
         bchk(5'h2, 16'hffff);
         xfer(1'b1, PT, 32'h7);
         xfer(1'b0, LD, 32'h0);
         chk("load high", 32'ha5, {24'h0, q[7:0]});
         xfer(1'b1, PT, 32'h6);
         xfer(1'b0, LD, 32'h0);
         chk("load low", 32'h03, {24'h0, q[7:0]});
      end
   endtask
   task t_eeprom;
      begin
         ld(16'h0000, 8'hab, 8'hcd);
         @(posedge clk);
         busy <= 1'b1;
         cmd(8'h03);
         chk("erase", 32'h0, {31'h0, ers});
         @(posedge clk);
         busy <= 1'b0;
         bchk(5'h3, 16'hffff);
         bchk(5'h0, 16'hffff);
      end
   endtask
   task t_erase;
      begin
         xfer(1'b1, PT, 32'h1900);
         cmd(8'h83);
         chk("erase", 32'h1, {31'h0, ers});
         chk("halt", 32'h1, {31'h0, halt});
         xfer(1'b1, PT, 32'h0);
         chk("page", 32'd100, {25'h0, page});
         chk("irq", 32'h0, {31'h0, irq});
         wait_op;
         chk("halt", 32'h0, {31'h0, halt});
         chk("irq", 32'h1, {31'h0, irq});
         xfer(1'b0, CT, 32'h0);
         chk("enable bit", 32'h80, q & 32'hc1);
      end
   endtask
   task t_rww;
      begin
         ld(16'h0144, 8'h11, 8'h22);
         cmd(8'h03);
         chk("rww block", 32'h1, {31'h0, blk});
         chk("halt", 32'h0, {31'h0, halt});
         xfer(1'b0, CT, 32'h0);
         chk("busy flag", 32'h41, q & 32'h41);
         xfer(1'b0, LD, 32'h0);
         chk("blocked read", 32'h0, q);
         xfer(1'b1, PT, 32'h1900);
         xfer(1'b0, LD, 32'h0);
         chk("halting read", 32'h80, q);
         wait_op;
         chk("rww block", 32'h1, {31'h0, blk});
         ld(16'h0140, 8'h33, 8'h44);
         chk("rww block", 32'h0, {31'h0, blk});
         cmd(8'h11);
         bchk(5'h2, 16'hffff);
         bchk(5'h0, 16'hffff);
      end
   endtask
   task t_write;
      begin
         ld(16'h1900, 8'h9a, 8'hbc);
         cmd(8'h05);
         chk("program", 32'h1, {31'h0, prg});
         chk("halt", 32'h1, {31'h0, halt});
         chk("page", 32'd100, {25'h0, page});
         wait_op;
         chk("halt", 32'h0, {31'h0, halt});
         bchk(5'h0, 16'hffff);
      end
   endtask
   task t_lock;
      integer i;
      begin
         xfer(1'b1, PT, 32'h1900);
         xfer(1'b1, DL, 32'hc7);
         cmd(8'h09);
         chk("halt", 32'h0, {31'h0, halt});
         q = 32'h1;
         for (i = 0; i < 40 && q[0] !== 1'b0; i = i + 1)
            xfer(1'b0, CT, 32'h0);
         chk("lock bits", 32'h1, {28'h0, lock});
         xfer(1'b1, PT, 32'h1);
         xfer(1'b1, CT, 32'h9);
         xfer(1'b0, LD, 32'h0);
         chk("lock read", 32'hc7, {24'h0, q[7:0]});
         xfer(1'b1, CT, 32'h9);
         busy <= 1'b1;
         xfer(1'b0, LD, 32'h0);
         chk("lock read busy", 32'h0, q);
         busy <= 1'b0;
      end
   endtask
   task t_bad;
      integer i;
      begin
         for (i = 0; i < 4; i = i + 1) begin
            xfer(1'b1, CT, 32'h02 + 32'h06 * i);
            xfer(1'b0, CT, 32'h0);
            chk("ctrl", 32'h0, q & 32'h1f);
            cmd(8'h02 + 8'h06 * i[7:0]);
            chk("op", 32'h0, {31'h0, ers | prg});
         end
         xfer(1'b1, PT, 32'h0);
         xfer(1'b1, CT, 32'h1);
         repeat (6) @(posedge clk);
         xfer(1'b0, CT, 32'h0);
         chk("enable timeout", 32'h0, q & 32'h1f);
         xfer(1'b1, ST, 32'h0);
         bchk(5'h0, 16'hffff);
      end
   endtask
   // Reset in mid-run clears the buffer and the lock bits
   task t_rst_mid;
      begin
         ld(16'h0006, 8'h55, 8'h66);
         bchk(5'h3, 16'h5566);
         @(posedge clk);
         rst <= 1'b1;
         repeat (2) @(posedge clk);
         rst <= 1'b0;
         chk("lock after reset", 32'hf, {28'h0, lock});
         bchk(5'h3, 16'hffff);
      end
   endtask
   task summarize;
      begin
         $display("checked %0d mismatches %0d", samples_checked, mismatches);
         if (mismatches == 0 && samples_checked > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask
   // Main sequence
   initial begin
      mismatches = 0;
      samples_checked = 0;
      cyc = 0;
      rst = 1'b1;
      hsel = 1'b1;
      hwrite = 1'b0;
      busy = 1'b0;
      haddr = 32'h0;
      hwdata = 32'h0;
      htrans = 2'h0;
      bidx = 5'h0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      t_reset;
      $display("reset test done");
      t_load;
      $display("load test done");
      t_eeprom;
      $display("eeprom test done");
      t_erase;
      $display("erase test done");
      t_rww;
      $display("rww test done");
      t_write;
      $display("write test done");
      t_lock;
      $display("lock test done");
      t_bad;
      $display("bad pattern test done");
      t_rst_mid;
      $display("mid reset test done");
      summarize;
   end
endmodule
